/* rtl/tone_generator.sv */
// Square-wave tone generator with an AXI4-Lite register slave.
//
// Contract
// RULE_01: Six-bit up-counter, period register, clock selector.
// RULE_02: Output is a 50 percent square wave.
// RULE_03: Pin carries tone only when function bit 3 set.
// RULE_04: Software sets pin direction bit 3 to output.
// RULE_05: Period value is bits 5 to 0.
// RULE_06: Frequency is oscillator over two, ratio, period plus one.
// RULE_07: Software loads period 1 to 3F before use.
// RULE_08: Period register is write-only; reads return zero.
// RULE_09: Each period write clears and restarts the counter.
// RULE_10: Counter increments from zero on each prescaled tick.
// RULE_11: On match toggle output and clear counter.
// RULE_12: Bits 7:6 pick ratios 4, 8, 16, 32.
`timescale 1ns/1ps
module tone_generator
(
   // Clock and reset.
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   // AXI4-Lite write address and data.
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response.
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read.
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [11:0] s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Port pin.
   output logic             tone_output_pin_o,
   output logic             tone_routed_o
);
   typedef struct packed
   {
      logic        aw_held;
      logic [11:0] aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [7:0]  func_sel;
      logic [7:0]  period;
      logic        period_loaded;
      logic [5:0]  count;
      logic        wave;
      logic        pin;
      logic        restart;
      logic        aw_ready;
      logic        w_ready;
      logic        ar_ready;
   } tone_state_t;

   tone_state_t state_reg;
   tone_state_t state_next;
   logic        tick;
   logic        do_write;
   logic        do_read;

   // Word-aligned decode shared by both channels.
   function automatic logic [1:0] decode(input logic [11:0] addr);
      logic [1:0] sel;
      sel = 2'h0;
      if (addr[11:2] == tone_pkg::FUNC_SEL_OFFSET[11:2])
      begin
         sel = 2'h1;
      end
      else if (addr[11:2] == tone_pkg::PERIOD_OFFSET[11:2])
      begin
         sel = 2'h2;
      end
      else if (addr[11:2] == tone_pkg::STATUS_OFFSET[11:2])
      begin
         sel = 2'h3;
      end
      return sel;
   endfunction

   // Ratio is restarted with the counter so a write gives a clean first half-period.
   tone_prescaler u_prescaler
   (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .restart_i (state_reg.restart),
      .select_i  (state_reg.period[tone_pkg::PRESC_SEL_MSB:tone_pkg::PRESC_SEL_LSB]),
      .tick_o    (tick)
   );

   assign do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
   // Reads finish in one cycle, so a new address waits only for the data to be taken.
   assign do_read  = s_axi_arvalid && !state_reg.rvalid;

   always_comb
   begin
      state_next         = state_reg;
      state_next.restart = 1'b0;
      if (s_axi_awvalid && !state_reg.aw_held)
      begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_reg.w_held)
      begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end
      if (state_reg.bvalid && s_axi_bready)
      begin
         state_next.bvalid = 1'b0;
      end
      if (do_write)
      begin
         state_next.aw_held = 1'b0;
         state_next.w_held  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = tone_pkg::RESP_OKAY;
         unique case (decode(state_reg.aw_addr))
            2'h1:
            begin
               if (state_reg.w_strb[0])
               begin
                  state_next.func_sel = state_reg.w_data[7:0];
               end
            end
            2'h2:
            begin
               if (state_reg.w_strb[0])
               begin
                  state_next.period        = state_reg.w_data[7:0]; // RULE_05
                  state_next.period_loaded = 1'b1;
                  state_next.restart       = 1'b1; // RULE_09
               end
            end
            2'h3: state_next.bresp = tone_pkg::RESP_SLVERR;
            2'h0: state_next.bresp = tone_pkg::RESP_DECERR;
         endcase
      end
      if (state_reg.rvalid && s_axi_rready)
      begin
         state_next.rvalid = 1'b0;
      end
      if (do_read)
      begin
         state_next.rvalid = 1'b1;
         state_next.rdata  = '0;
         state_next.rresp  = tone_pkg::RESP_OKAY;
         unique case (decode(s_axi_araddr))
            2'h1: state_next.rdata[7:0] = state_reg.func_sel;
            2'h2: state_next.rdata = '0; // RULE_08
            2'h3: state_next.rdata[7:0] = {state_reg.period_loaded, state_reg.wave,
                                           state_reg.count};
            2'h0: state_next.rresp = tone_pkg::RESP_DECERR;
         endcase
      end
      // Counter and toggle run off the prescaled tick.
      if (state_reg.restart)
      begin
         state_next.count = tone_pkg::CNT_ZERO; // RULE_09
      end
      else if (tick)
      begin
         if (state_reg.count == state_reg.period[tone_pkg::PERIOD_MSB:tone_pkg::PERIOD_LSB])
         begin
            state_next.count = tone_pkg::CNT_ZERO; // RULE_11
            state_next.wave  = !state_reg.wave; // RULE_02 RULE_06
         end
         else
         begin
            state_next.count = state_reg.count + 6'h01; // RULE_10 RULE_01
         end
      end
      // Pin falls back low whenever the port function is not the tone.
      state_next.pin = state_reg.func_sel[tone_pkg::FUNC_TONE_BIT] && state_reg.wave; // RULE_03
      // Ready flags live in flops so each bus output leaves a register directly.
      state_next.aw_ready = !state_next.aw_held;
      state_next.w_ready  = !state_next.w_held;
      state_next.ar_ready = !state_next.rvalid;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         state_reg          <= '0;
         state_reg.func_sel <= tone_pkg::FUNC_RESET;
         state_reg.period   <= tone_pkg::PERIOD_RESET;
         state_reg.aw_ready <= 1'b1;
         state_reg.w_ready  <= 1'b1;
         state_reg.ar_ready <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign s_axi_awready     = state_reg.aw_ready;
   assign s_axi_wready      = state_reg.w_ready;
   assign s_axi_bvalid      = state_reg.bvalid;
   assign s_axi_bresp       = state_reg.bresp;
   assign s_axi_arready     = state_reg.ar_ready;
   assign s_axi_rvalid      = state_reg.rvalid;
   assign s_axi_rdata       = state_reg.rdata;
   assign s_axi_rresp       = state_reg.rresp;
   assign tone_output_pin_o = state_reg.pin;
   assign tone_routed_o     = state_reg.func_sel[tone_pkg::FUNC_TONE_BIT];

   sequence period_write_s;
      do_write && decode(state_reg.aw_addr) == 2'h2 && state_reg.w_strb[0];
   endsequence

   restart_clears_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_09
      period_write_s |=> ##1 state_reg.count == tone_pkg::CNT_ZERO)
      else $error("Counter not cleared after period write.");

   count_step_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_10
      tick && !state_reg.restart && state_reg.count != state_reg.period[5:0]
      |=> state_reg.count == $past(state_reg.count) + 6'h01)
      else $error("Counter did not step on tick.");

   match_toggle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_11
      tick && !state_reg.restart && state_reg.count == state_reg.period[5:0]
      |=> state_reg.count == tone_pkg::CNT_ZERO && state_reg.wave != $past(state_reg.wave))
      else $error("Match did not toggle and clear.");

   wave_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_02
      !tick |=> $stable(state_reg.wave))
      else $error("Wave changed without a tick.");

   pin_route_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_03
      !state_reg.func_sel[3] |=> !tone_output_pin_o)
      else $error("Tone reached pin while not selected.");

   pin_follow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_03
      state_reg.func_sel[3] |=> tone_output_pin_o == $past(state_reg.wave))
      else $error("Pin does not follow the wave.");

   period_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_08
      do_read && decode(s_axi_araddr) == 2'h2 |=> s_axi_rvalid && s_axi_rdata == 32'h0)
      else $error("Period register read back data.");

   period_field_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_05
      period_write_s |=> state_reg.period[5:0] == $past(state_reg.w_data[5:0]))
      else $error("Period field not taken from low bits.");

   count_bound_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_01
      state_reg.period_loaded && !state_reg.restart && $stable(state_reg.period)
      && state_reg.count <= state_reg.period[5:0]
      |=> state_reg.count <= state_reg.period[5:0])
      else $error("Counter passed the period value.");

   write_resp_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_09
      do_write |=> s_axi_bvalid)
      else $error("Write response missing.");

   sequence tick_quiet_s;
      !tick [*4];
   endsequence

   // A period write restarts the prescaler too, so the first tick is a full ratio away.
   restart_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_09
      state_reg.restart |=> tick_quiet_s)
      else $error("Tick came too soon after a restart.");

   count_start_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_10
      state_reg.restart |=> (state_reg.count == tone_pkg::CNT_ZERO) [*4])
      else $error("Counter left zero before the first tick.");

   // Four clocks is the shortest ratio, so no two ticks may come closer.
   tick_gap_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_12
      tick |=> !tick [*3])
      else $error("Prescaler ticks closer than the shortest ratio.");

   count_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_10
      !tick && !state_reg.restart |=> $stable(state_reg.count))
      else $error("Counter moved without a tick.");

   wave_cause_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_02
      $changed(state_reg.wave) |-> $past(tick) && !$past(state_reg.restart))
      else $error("Wave flipped outside a counted tick.");

   status_count_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_01
      do_read && decode(s_axi_araddr) == 2'h3 |=> s_axi_rdata[5:0] == $past(state_reg.count))
      else $error("Status did not report the counter.");

   read_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RULE_08
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data changed before it was taken.");
endmodule

/* rtl/tone_pkg.sv */
// Package with register map, field layout and timing constants of the tone generator.
package tone_pkg;
   localparam int          ADDR_W           = 12;
   localparam int          DATA_W           = 32;
   localparam int          CNT_W            = 6;
   localparam int          PRESC_W          = 5;
   localparam logic [11:0] FUNC_SEL_OFFSET  = 12'h0f4;
   localparam logic [11:0] PERIOD_OFFSET    = 12'h0f8;
   localparam logic [11:0] STATUS_OFFSET    = 12'h0fc;
   localparam int          FUNC_TONE_BIT    = 3;
   localparam int          PERIOD_LSB       = 0;
   localparam int          PERIOD_MSB       = 5;
   localparam int          PRESC_SEL_LSB    = 6;
   localparam int          PRESC_SEL_MSB    = 7;
   localparam logic [7:0]  FUNC_RESET       = 8'h00;
   localparam logic [7:0]  PERIOD_RESET     = 8'h00;
   localparam logic [5:0]  CNT_ZERO         = 6'h00;
   localparam logic [4:0]  PRESC_LAST_R4    = 5'h03;
   localparam logic [4:0]  PRESC_LAST_R8    = 5'h07;
   localparam logic [4:0]  PRESC_LAST_R16   = 5'h0f;
   localparam logic [4:0]  PRESC_LAST_R32   = 5'h1f;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;
   localparam logic [1:0]  RESP_DECERR      = 2'h3;
endpackage

/* rtl/tone_prescaler.sv */
// Free-running oscillator prescaler that gives a one-cycle tick at the selected ratio.
`timescale 1ns/1ps
module tone_prescaler
(
   // Clock and reset.
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   // Control.
   input  wire logic       restart_i,
   input  wire logic [1:0] select_i,
   // Tick out.
   output logic            tick_o
);
   typedef struct packed
   {
      logic [tone_pkg::PRESC_W-1:0] div;
      logic                         tick;
   } presc_state_t;

   presc_state_t state_reg;
   presc_state_t state_next;
   logic [tone_pkg::PRESC_W-1:0] last_div;

   // Codes 00 to 11 give ratios 4, 8, 16 and 32.
   always_comb
   begin
      last_div = tone_pkg::PRESC_LAST_R4;
      unique case (select_i)
         2'h0: last_div = tone_pkg::PRESC_LAST_R4; // RULE_12
         2'h1: last_div = tone_pkg::PRESC_LAST_R8; // RULE_12
         2'h2: last_div = tone_pkg::PRESC_LAST_R16; // RULE_12
         2'h3: last_div = tone_pkg::PRESC_LAST_R32; // RULE_12
      endcase
   end

   always_comb
   begin
      state_next      = state_reg;
      state_next.tick = 1'b0;
      if (restart_i)
      begin
         state_next.div = '0;
      end
      else if (state_reg.div >= last_div)
      begin
         state_next.div  = '0;
         state_next.tick = 1'b1;
      end
      else
      begin
         state_next.div = state_reg.div + 5'h01;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign tick_o = state_reg.tick;
endmodule

/* tb/buzzer_model.sv */
// Piezo sounder model that times the half-periods seen on the tone pin.
`timescale 1ns/1ps
module buzzer_model
(
   // Clock.
   input  wire logic        ref_clk_i,
   // Pin side.
   input  wire logic        pin_i,
   input  wire logic        dir_i,
   // Measurements.
   output logic [15:0]      half_o,
   output logic [15:0]      prev_o,
   output logic [15:0]      edges_o
);
   logic        last  = 1'b0;
   logic [15:0] run   = 16'h0000;
   logic [15:0] half  = 16'h0000;
   logic [15:0] prev  = 16'h0000;
   logic [15:0] edges = 16'h0000;

   assign half_o  = half;
   assign prev_o  = prev;
   assign edges_o = edges;

   // A pin left in input mode drives nothing, so the sounder only hears it as an output.
   always @(posedge ref_clk_i)
   begin
      if (dir_i && pin_i !== last)
      begin
         prev  <= half;
         half  <= run;
         run   <= 16'h0001;
         edges <= edges + 16'h0001;
      end
      else
      begin
         run <= run + 16'h0001;
      end
      last <= pin_i;
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the tone generator and its register slave.
`timescale 1ns/1ps
module testbench;
   logic        ref_clk = 1'b0, resetn = 1'b0, dir = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr  = 12'h000, araddr = 12'h000;
   logic [31:0] wdata   = 32'h00000000, rdata, rd, wd;
   logic        awready, wready, bvalid, arready, rvalid, pin, routed;
   logic [1:0]  bresp, rresp, resp;
   logic [15:0] half, prev, edges;
   int          n_fail = 0, compares = 0, seed = 80841, code, p;

   always #2 ref_clk = ~ref_clk;

   tone_generator i_dut (.ref_clk_i(ref_clk), .resetn_i(resetn),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .tone_output_pin_o(pin),
      .tone_routed_o(routed));

   buzzer_model i_buz (.ref_clk_i(ref_clk), .pin_i(pin), .dir_i(dir), .half_o(half),
      .prev_o(prev), .edges_o(edges));

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t response %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      n_fail++;
      $display("[FAIL] %0t wait ran out", $time);
      end_of_test();
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge ref_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      if (n == 100)
         hang();
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a);
      int n;
      @(posedge ref_clk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge ref_clk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      if (n == 100)
         hang();
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // Edge counts only grow, so a stuck pin ends here on the bound.
   task automatic wait_edges(input int k);
      int s;
      int n;
      s = edges;
      for (n = 0; n < 10000; n++)
      begin
         @(posedge ref_clk);
         if (edges >= s + k)
            break;
      end
      if (n == 10000)
         hang();
   endtask

   function automatic int half_len(input int c, input int per);
      return (4 << c) * (per + 1);
   endfunction

   initial
   begin
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      rd_reg(tone_pkg::FUNC_SEL_OFFSET);
      chk_data(rd, 32'h00000000);
      rd_reg(tone_pkg::PERIOD_OFFSET);
      chk_data(rd, 32'h00000000);
      wr(tone_pkg::PERIOD_OFFSET, 32'h00000001);
      dir <= 1'b1;
      repeat (100) @(posedge ref_clk);
      chk_data({16'h0000, edges}, 32'h00000000);
      wr(tone_pkg::FUNC_SEL_OFFSET, 32'h00000008);
      chk_resp(resp, tone_pkg::RESP_OKAY);
      rd_reg(tone_pkg::FUNC_SEL_OFFSET);
      chk_data(rd & 32'h000000ff, 32'h00000008);
      chk_data({31'h0, routed}, 32'h00000001);
      for (int i = 0; i < 6; i++)
      begin
         code = i % 4;
         p = (i == 0) ? 1 : (i == 1) ? 63 : 1 + {$random(seed)} % 63;
         wd = $random(seed);
         wd[7:0] = {code[1:0], p[5:0]};
         wr(tone_pkg::PERIOD_OFFSET, wd);
         rd_reg(tone_pkg::STATUS_OFFSET);
         chk_data(rd & 32'h000000bf, 32'h00000080);
         wait_edges(4);
         chk_data({16'h0000, half}, half_len(code, p));
         chk_data({16'h0000, prev}, half_len(code, p));
      end
      rd_reg(12'h100);
      chk_resp(resp, tone_pkg::RESP_DECERR);
      wr(tone_pkg::STATUS_OFFSET, 32'h00000000);
      chk_resp(resp, tone_pkg::RESP_SLVERR);
      wr(tone_pkg::FUNC_SEL_OFFSET, 32'h00000000);
      repeat (4) @(posedge ref_clk);
      chk_data({31'h0, pin}, 32'h00000000);
      end_of_test();
   end
endmodule
